// ===== cpu_mem_model.sv
`default_nettype none
module cpu_mem_model #(
  parameter logic [15:0] boot_pc = 16'hC3A5
) (
  input  wire logic        clk,       // CPU clock
  input  wire logic [15:0] mem_addr,  // Byte address
  input  wire logic        mem_rd,    // Read strobe
  input  wire logic        mem_wr,    // Write strobe
  input  wire logic [7:0]  mem_wdata, // Write data
  output var  logic [7:0]  mem_rdata  // Read data, cycle after strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  initial
  begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    mem[16'hFFFE] = boot_pc[7:0];
    mem[16'hFFFF] = boot_pc[15:8];
    mem_rdata = 8'h00;
  end
  // Data only stands in the cycle after a read, else it keeps toggling
  always @(posedge clk)
  begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (mem_rd) mem_rdata <= mem[mem_addr];
    else mem_rdata <= ~mem_rdata;
  end
endmodule
`default_nettype wire

// ===== cpu_register_file_flags.v
// What this block does
// - Reset forces the interrupt mask flag to one.
// - After reset, PC low comes from FFFE, high from FFFF, then fetch.
// - Accumulator, index, stack pointer, decimal and index-mode flags are not reset.
// - Indexed effective address is operand plus selected index register.
// - Index mode zero writes accumulator; one writes memory addressed by X.
// - Stack pointer holds the low address of the next push.
// - Stack page select bit picks page zero or page one.
// - Call pushes PC; interrupt and break push PC and flags; nothing else automatic.
// - Separate push and pull operations for accumulator and flags.
// - Carry takes ALU carry or borrow, shifts, rotates, set and clear.
// - Zero flag reflects a zero arithmetic or transfer result.
// - Mask refuses maskable interrupts, set on entry, set and clear ops.
// - Decimal flag makes add and subtract work on two BCD digits.
// - Stacked break bit is one for software break, zero for interrupts; flag push stores bit four as held.
// - Bit five is the index-mode flag with set and clear ops.
// - Overflow flags signed range exit, bit test loads it, clear op.
// - Negative copies result bit seven; bit test loads memory bit seven.
// - One 64K address space for every memory and register.
// - Two-byte forms reach the zero page and the special page.
// - Program counter is 16 bits of separately addressable bytes.
//
// Strobed register access and the address map were decided locally.
`include "cpu_regs_defs.vh"
`default_nettype none
module cpu_register_file_flags (
  input  wire        clk,        // CPU clock
  input  wire        srst,       // Synchronous reset, active high
  input  wire [3:0]  reg_addr,   // Register bus address
  input  wire [7:0]  reg_wdata,  // Register bus write data
  input  wire        reg_wr,     // Register bus write strobe
  input  wire        reg_rd,     // Register bus read strobe
  output reg  [7:0]  reg_rdata,  // Read data, cycle after strobe
  input  wire        op_valid,   // Operation request
  input  wire [4:0]  op_code,    // Operation code
  input  wire [1:0]  op_sel,     // Load target: A, X, Y, S
  input  wire [7:0]  op_data,    // Operand byte
  input  wire [7:0]  op_mem1,    // Memory byte at X for index mode
  input  wire [15:0] op_addr,    // Operand address or PC value
  input  wire [1:0]  op_form,    // Address form
  input  wire [1:0]  op_index,   // Index select
  output wire        op_ready,   // Operation accepted when high
  input  wire        irq_req,    // Maskable interrupt request level
  output reg         irq_ack,    // Interrupt accepted pulse
  output reg  [15:0] ea_addr,    // Effective address, one cycle late
  output reg  [15:0] mem_addr,   // Memory address
  output reg         mem_rd,     // Memory read strobe
  output reg         mem_wr,     // Memory write strobe
  output reg  [7:0]  mem_wdata,  // Memory write data
  input  wire [7:0]  mem_rdata,  // Read data, cycle after strobe
  output reg         fetch,      // Instruction fetch at PC pulse
  output reg  [7:0]  accumulator, // Accumulator
  output reg  [7:0]  processor_flags, // Status flags
  output reg  [15:0] pc          // Program counter
);
  localparam [3:0] ST_VEC_LO = 4'h0;
  localparam [3:0] ST_VEC_HI = 4'h1;
  localparam [3:0] ST_GET_LO = 4'h2;
  localparam [3:0] ST_GET_HI = 4'h3;
  localparam [3:0] ST_IDLE   = 4'h4;
  localparam [3:0] ST_PSH_H  = 4'h5;
  localparam [3:0] ST_PSH_L  = 4'h6;
  localparam [3:0] ST_PSH_P  = 4'h7;
  localparam [3:0] ST_PULL_W = 4'h8;
  localparam [3:0] ST_PULL_D = 4'h9;

  reg [3:0] state;
  reg [7:0] index_x;
  reg [7:0] index_y;
  reg [7:0] stack_pointer;
  reg [7:0] cpu_mode;
  reg       push_flags_too;
  reg       break_mark;
  reg       pull_to_flags;
  reg [9:0] alu;
  reg [7:0] shift_res;
  reg       shift_c;

  // Address of the stack slot for a pointer value
  function [15:0] stack_addr;
    input [7:0] sp;
    input       page;
    begin
      stack_addr = {7'h00, page, sp};
    end
  endfunction

  // {carry, overflow, result}
  function [9:0] add_sub;
    input [7:0] a;
    input [7:0] b;
    input       ci;
    input       sub;
    input       dec;
    reg   [7:0] bb;
    reg   [8:0] sum;
    reg   [4:0] lo;
    reg   [4:0] hi;
    reg         v;
    begin
      bb  = sub ? ~b : b;
      sum = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
      v   = (a[7] == bb[7]) && (sum[7] != a[7]);
      lo  = 5'h00;
      hi  = 5'h00;
      if (!dec)
        add_sub = {sum[8], v, sum[7:0]};
      else if (!sub)
      begin
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        if (lo > 5'h09)
          lo = lo + 5'h06;
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        if (hi > 5'h09)
          hi = hi + 5'h06;
        add_sub = {hi[4], v, hi[3:0], lo[3:0]};
      end
      else
      begin
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~ci};
        if (lo[4])
          lo = lo - 5'h06;
        hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo[4]};
        if (hi[4])
          hi = hi - 5'h06;
        add_sub = {~hi[4], v, hi[3:0], lo[3:0]};
      end
    end
  endfunction

  // Negative and zero from a result byte
  function [1:0] neg_zero;
    input [7:0] r;
    begin
      neg_zero = {r[7], r == 8'h00};
    end
  endfunction

  wire irq_take = irq_req && !processor_flags[`FLG_IRQ_MASK];
  assign op_ready = (state == ST_IDLE) && !irq_take;
  wire op_go = op_valid && op_ready;
  wire [7:0] left_opd = processor_flags[`FLG_XMODE] ? op_mem1 : accumulator;
  wire [15:0] pushed_sp = stack_addr(stack_pointer, cpu_mode[`MODE_STACK_PAGE]);
  wire [7:0] sp_up = stack_pointer + 8'h01;
  wire [1:0] nz_data = neg_zero(op_data);
  wire [1:0] nz_alu = neg_zero(alu[7:0]);
  wire [1:0] nz_shift = neg_zero(shift_res);

  always @*
  begin
    alu = add_sub(left_opd, op_data, processor_flags[`FLG_CARRY],
                  op_code == `OP_SUB, processor_flags[`FLG_DECIMAL]);
    shift_c = 1'b0;
    shift_res = accumulator;
    case (op_code)
      `OP_SHL:
      begin
        shift_c = accumulator[7];
        shift_res = {accumulator[6:0], 1'b0};
      end
      `OP_ROL:
      begin
        shift_c = accumulator[7];
        shift_res = {accumulator[6:0], processor_flags[`FLG_CARRY]};
      end
      `OP_SHR:
      begin
        shift_c = accumulator[0];
        shift_res = {1'b0, accumulator[7:1]};
      end
      `OP_ROR:
      begin
        shift_c = accumulator[0];
        shift_res = {processor_flags[`FLG_CARRY], accumulator[7:1]};
      end
      default:
      begin
        shift_c = 1'b0;
        shift_res = accumulator;
      end
    endcase
  end

  // Effective address over the single 64K space
  always @(posedge clk)
  begin
    if (srst)
      ea_addr <= 16'h0000;
    else
    begin
      case (op_form)
        `FORM_ZERO:
          ea_addr <= {`ZERO_PAGE, op_addr[7:0] + (op_index == `IDX_X ? index_x :
                     (op_index == `IDX_Y ? index_y : 8'h00))};
        `FORM_SPECIAL:
          ea_addr <= {`SPECIAL_PAGE, op_addr[7:0]};
        default:
          ea_addr <= op_addr + {8'h00, (op_index == `IDX_X ? index_x :
                     (op_index == `IDX_Y ? index_y : 8'h00))};
      endcase
    end
  end

  // Register bus read
  always @(posedge clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `OFS_ACCUM:     reg_rdata <= accumulator;
        `OFS_INDEX_X:   reg_rdata <= index_x;
        `OFS_INDEX_Y:   reg_rdata <= index_y;
        `OFS_STACK_PTR: reg_rdata <= stack_pointer;
        `OFS_PC_LOW:    reg_rdata <= pc[7:0];
        `OFS_PC_HIGH:   reg_rdata <= pc[15:8];
        `OFS_FLAGS:     reg_rdata <= processor_flags;
        `OFS_CPU_MODE:  reg_rdata <= cpu_mode;
        default:        reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // Data registers without reset
  always @(posedge clk)
  begin
    if (reg_wr && reg_addr == `OFS_ACCUM)
      accumulator <= reg_wdata;
    else if (state == ST_IDLE && op_go)
    begin
      if (op_code == `OP_LOAD && op_sel == 2'h0)
        accumulator <= op_data;
      else if ((op_code == `OP_ADD || op_code == `OP_SUB) && !processor_flags[`FLG_XMODE])
        accumulator <= alu[7:0];
      else if (op_code >= `OP_SHL && op_code <= `OP_ROR)
        accumulator <= shift_res;
    end
    else if (state == ST_PULL_D && !pull_to_flags)
      accumulator <= mem_rdata;
    if (reg_wr && reg_addr == `OFS_INDEX_X)
      index_x <= reg_wdata;
    else if (state == ST_IDLE && op_go && op_code == `OP_LOAD && op_sel == 2'h1)
      index_x <= op_data;
    if (reg_wr && reg_addr == `OFS_INDEX_Y)
      index_y <= reg_wdata;
    else if (state == ST_IDLE && op_go && op_code == `OP_LOAD && op_sel == 2'h2)
      index_y <= op_data;
  end

  // Sequencer, stack, program counter and flags
  always @(posedge clk)
  begin
    if (srst)
    begin
      state <= ST_VEC_LO;
      processor_flags[`FLG_IRQ_MASK] <= 1'b1;
      pc <= 16'h0000;
      cpu_mode <= `MODE_RESET;
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
      fetch <= 1'b0;
      irq_ack <= 1'b0;
      push_flags_too <= 1'b0;
      break_mark <= 1'b0;
      pull_to_flags <= 1'b0;
    end
    else
    begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      fetch <= 1'b0;
      irq_ack <= 1'b0;
      if (reg_wr && reg_addr == `OFS_CPU_MODE)
        cpu_mode <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_STACK_PTR)
        stack_pointer <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_FLAGS)
        processor_flags <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_PC_LOW)
        pc[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_PC_HIGH)
        pc[15:8] <= reg_wdata;
      case (state)
        ST_VEC_LO:
        begin
          mem_addr <= `VEC_LOW_ADDR;
          mem_rd <= 1'b1;
          state <= ST_VEC_HI;
        end
        ST_VEC_HI:
        begin
          mem_addr <= `VEC_HIGH_ADDR;
          mem_rd <= 1'b1;
          state <= ST_GET_LO;
        end
        ST_GET_LO:
        begin
          pc[7:0] <= mem_rdata;
          state <= ST_GET_HI;
        end
        ST_GET_HI:
        begin
          pc[15:8] <= mem_rdata;
          mem_addr <= {mem_rdata, pc[7:0]};
          mem_rd <= 1'b1;
          fetch <= 1'b1;
          state <= ST_IDLE;
        end
        ST_IDLE:
        begin
          if (irq_take)
          begin
            irq_ack <= 1'b1;
            push_flags_too <= 1'b1;
            break_mark <= 1'b0;
            state <= ST_PSH_H;
          end
          else if (op_go)
          begin
            case (op_code)
              `OP_LOAD:
                if (op_sel == 2'h3)
                  stack_pointer <= op_data;
                else
                  processor_flags[`FLG_NEGATIVE:`FLG_ZERO] <=
                    {nz_data[1], processor_flags[6:2], nz_data[0]};
              `OP_ADD, `OP_SUB:
              begin
                processor_flags[`FLG_CARRY] <= alu[9];
                processor_flags[`FLG_OVERFLOW] <= alu[8];
                processor_flags[`FLG_NEGATIVE] <= nz_alu[1];
                processor_flags[`FLG_ZERO] <= nz_alu[0];
                if (processor_flags[`FLG_XMODE])
                begin
                  mem_addr <= {`ZERO_PAGE, index_x};
                  mem_wdata <= alu[7:0];
                  mem_wr <= 1'b1;
                end
              end
              `OP_SHL, `OP_ROL, `OP_SHR, `OP_ROR:
              begin
                processor_flags[`FLG_CARRY] <= shift_c;
                processor_flags[`FLG_NEGATIVE] <= nz_shift[1];
                processor_flags[`FLG_ZERO] <= nz_shift[0];
              end
              `OP_BIT_TEST:
              begin
                processor_flags[`FLG_NEGATIVE] <= op_data[7];
                processor_flags[`FLG_OVERFLOW] <= op_data[6];
                processor_flags[`FLG_ZERO] <= (accumulator & op_data) == 8'h00;
              end
              `OP_SET_C: processor_flags[`FLG_CARRY] <= 1'b1;
              `OP_CLR_C: processor_flags[`FLG_CARRY] <= 1'b0;
              `OP_SET_I: processor_flags[`FLG_IRQ_MASK] <= 1'b1;
              `OP_CLR_I: processor_flags[`FLG_IRQ_MASK] <= 1'b0;
              `OP_SET_D: processor_flags[`FLG_DECIMAL] <= 1'b1;
              `OP_CLR_D: processor_flags[`FLG_DECIMAL] <= 1'b0;
              `OP_SET_T: processor_flags[`FLG_XMODE] <= 1'b1;
              `OP_CLR_T: processor_flags[`FLG_XMODE] <= 1'b0;
              `OP_CLR_V: processor_flags[`FLG_OVERFLOW] <= 1'b0;
              `OP_PUSH_A, `OP_PUSH_P:
              begin
                mem_addr <= pushed_sp;
                mem_wdata <= (op_code == `OP_PUSH_A) ? accumulator : processor_flags;
                mem_wr <= 1'b1;
                stack_pointer <= stack_pointer - 8'h01;
              end
              `OP_PULL_A, `OP_PULL_P:
              begin
                mem_addr <= stack_addr(sp_up, cpu_mode[`MODE_STACK_PAGE]);
                mem_rd <= 1'b1;
                stack_pointer <= sp_up;
                pull_to_flags <= (op_code == `OP_PULL_P);
                state <= ST_PULL_W;
              end
              `OP_CALL, `OP_BREAK:
              begin
                push_flags_too <= (op_code == `OP_BREAK);
                break_mark <= (op_code == `OP_BREAK);
                state <= ST_PSH_H;
              end
              `OP_PC_LOAD: pc <= op_addr;
              `OP_PC_INC:
              begin
                pc <= pc + 16'h0001;
                mem_addr <= pc + 16'h0001;
                mem_rd <= 1'b1;
                fetch <= 1'b1;
              end
              default: state <= ST_IDLE;
            endcase
          end
        end
        ST_PSH_H, ST_PSH_L:
        begin
          mem_addr <= pushed_sp;
          mem_wdata <= (state == ST_PSH_H) ? pc[15:8] : pc[7:0];
          mem_wr <= 1'b1;
          stack_pointer <= stack_pointer - 8'h01;
          if (state == ST_PSH_H)
            state <= ST_PSH_L;
          else if (push_flags_too)
            state <= ST_PSH_P;
          else
            state <= ST_IDLE;
        end
        ST_PSH_P:
        begin
          mem_addr <= pushed_sp;
          mem_wdata <= {processor_flags[7:5], break_mark, processor_flags[3:0]};
          mem_wr <= 1'b1;
          stack_pointer <= stack_pointer - 8'h01;
          processor_flags[`FLG_IRQ_MASK] <= 1'b1;
          state <= ST_IDLE;
        end
        ST_PULL_W:
          state <= ST_PULL_D;
        ST_PULL_D:
        begin
          if (pull_to_flags)
            processor_flags <= mem_rdata;
          state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== cpu_register_file_flags_assertions.sv
`include "cpu_regs_defs.vh"
`default_nettype none
module cpu_regs_checker (
  input wire logic        clk,             // CPU clock
  input wire logic        srst,            // Reset
  input wire logic        op_valid,        // Operation request
  input wire logic [4:0]  op_code,         // Operation code
  input wire logic [15:0] op_addr,         // Operand address
  input wire logic [1:0]  op_form,         // Address form
  input wire logic [1:0]  op_index,        // Index select
  input wire logic        op_ready,        // Operation accepted
  input wire logic        irq_req,         // Interrupt request
  input wire logic        irq_ack,         // Interrupt accepted
  input wire logic [15:0] ea_addr,         // Effective address
  input wire logic [15:0] mem_addr,        // Memory address
  input wire logic        mem_rd,          // Memory read
  input wire logic        mem_wr,          // Memory write
  input wire logic [7:0]  mem_wdata,       // Memory write data
  input wire logic        fetch,           // Fetch pulse
  input wire logic [7:0]  accumulator,     // Accumulator
  input wire logic [7:0]  processor_flags, // Flags
  input wire logic [15:0] pc               // Program counter
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic taken;
  assign taken = op_valid && op_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  mask_after_reset_a: assert property ($fell(srst) |-> processor_flags[2])
    else $error("mask flag clear after reset");
  vector_reads_a: assert property ($fell(srst) |=> mem_rd && mem_addr == 16'hFFFE
    ##1 mem_rd && mem_addr == 16'hFFFF) else $error("vector reads out of order");
  fetch_at_pc_a: assert property (fetch |-> mem_rd && mem_addr == pc)
    else $error("fetch not at program counter");
  plain_ea_a: assert property (!$past(srst) && $past(op_index == 2'h0 && op_form != 2'h3)
    |-> ea_addr == ($past(op_form) == 2'h1 ? {8'h00, $past(op_addr[7:0])} :
    $past(op_form) == 2'h2 ? {8'hFF, $past(op_addr[7:0])} : $past(op_addr)))
    else $error("effective address wrong");
  irq_gate_a: assert property ($rose(irq_ack) |-> $past(irq_req && !processor_flags[2]))
    else $error("interrupt taken while masked");
  irq_entry_a: assert property (irq_ack |=> mem_wr ##1 mem_wr
    ##1 (mem_wr && !mem_wdata[4]) ##1 processor_flags[2]) else $error("interrupt entry wrong");
  break_stack_a: assert property (taken && op_code == `OP_BREAK |=> ##1 mem_wr ##1 mem_wr
    ##1 (mem_wr && mem_wdata[4])) else $error("break stacking wrong");
  push_accum_a: assert property (taken && op_code == `OP_PUSH_A |=> mem_wr
    && mem_wdata == $past(accumulator) && mem_addr[15:9] == 7'h00) else $error("push wrong");
  carry_ops_a: assert property (taken && (op_code == `OP_SET_C || op_code == `OP_CLR_C)
    |=> processor_flags[0] == ($past(op_code) == `OP_SET_C)) else $error("carry op wrong");
  cover property (irq_ack);
  cover property (fetch);
  cover property (taken && op_code == `OP_BREAK);
endmodule
bind cpu_register_file_flags cpu_regs_checker chk_u (.clk, .srst, .op_valid, .op_code, .op_addr,
  .op_form, .op_index, .op_ready, .irq_req, .irq_ack, .ea_addr, .mem_addr, .mem_rd, .mem_wr,
  .mem_wdata, .fetch, .accumulator, .processor_flags, .pc);
`default_nettype wire

// ===== cpu_regs_defs.vh
`ifndef CPU_REGS_DEFS_VH
`define CPU_REGS_DEFS_VH
// Register bus offsets
`define OFS_ACCUM      4'h0
`define OFS_INDEX_X    4'h1
`define OFS_INDEX_Y    4'h2
`define OFS_STACK_PTR  4'h3
`define OFS_PC_LOW     4'h4
`define OFS_PC_HIGH    4'h5
`define OFS_FLAGS      4'h6
`define OFS_CPU_MODE   4'h7
// Flag bit positions
`define FLG_CARRY      0
`define FLG_ZERO       1
`define FLG_IRQ_MASK   2
`define FLG_DECIMAL    3
`define FLG_BREAK      4
`define FLG_XMODE      5
`define FLG_OVERFLOW   6
`define FLG_NEGATIVE   7
`define MODE_STACK_PAGE 2
// Reset vector and pages
`define VEC_LOW_ADDR   16'hFFFE
`define VEC_HIGH_ADDR  16'hFFFF
`define ZERO_PAGE      8'h00
`define SPECIAL_PAGE   8'hFF
`define MODE_RESET     8'h00
// Operation codes
`define OP_NOP         5'h00
`define OP_LOAD        5'h01
`define OP_ADD         5'h02
`define OP_SUB         5'h03
`define OP_SHL         5'h04
`define OP_ROL         5'h05
`define OP_SHR         5'h06
`define OP_ROR         5'h07
`define OP_BIT_TEST    5'h08
`define OP_SET_C       5'h09
`define OP_CLR_C       5'h0A
`define OP_SET_I       5'h0B
`define OP_CLR_I       5'h0C
`define OP_SET_D       5'h0D
`define OP_CLR_D       5'h0E
`define OP_SET_T       5'h0F
`define OP_CLR_T       5'h10
`define OP_CLR_V       5'h11
`define OP_PUSH_A      5'h12
`define OP_PULL_A      5'h13
`define OP_PUSH_P      5'h14
`define OP_PULL_P      5'h15
`define OP_CALL        5'h16
`define OP_BREAK       5'h17
`define OP_PC_LOAD     5'h18
`define OP_PC_INC      5'h19
// Address forms
`define FORM_ABS       2'h0
`define FORM_ZERO      2'h1
`define FORM_SPECIAL   2'h2
`define IDX_NONE       2'h0
`define IDX_X          2'h1
`define IDX_Y          2'h2
`endif

// ===== tb.sv
`include "cpu_regs_defs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] BOOT = 16'hC3A5;
  logic        clk, srst, reg_wr, reg_rd, op_valid, irq_req, op_ready, irq_ack;
  logic        mem_rd, mem_wr, fetch;
  logic [3:0]  reg_addr;
  logic [4:0]  op_code;
  logic [1:0]  op_sel, op_form, op_index;
  logic [7:0]  reg_wdata, reg_rdata, op_data, op_mem1, mem_wdata, mem_rdata;
  logic [7:0]  accumulator, processor_flags, rd_val;
  logic [15:0] op_addr, ea_addr, mem_addr, pc, snap;
  int          miscompares = 0;
  int          cmp_count = 0;
  cpu_register_file_flags dut_u (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .op_valid, .op_code, .op_sel, .op_data, .op_mem1, .op_addr, .op_form,
    .op_index, .op_ready, .irq_req, .irq_ack, .ea_addr, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata, .fetch, .accumulator, .processor_flags, .pc);
  cpu_mem_model #(.boot_pc(BOOT)) mem_u (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .mem_rdata);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task bus_rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // Holds the request until an edge sees op_ready high
  task do_op(input logic [4:0] c, input logic [1:0] s, input logic [7:0] d);
    int n;
    @(posedge clk);
    op_code <= c;
    op_sel <= s;
    op_data <= d;
    op_valid <= 1'b1;
    #1 n = 0;
    while (op_ready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 50) miscompares++;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task flag_op(input logic [4:0] c, input int b, input logic v);
    do_op(c, 2'h0, 8'h00);
    check(processor_flags[b], v);
  endtask
  task arith(input logic [4:0] c, input logic [7:0] d, input logic [7:0] a, input logic [3:0] f);
    do_op(c, 2'h0, d);
    check(accumulator, a);
    check({processor_flags[7:6], processor_flags[1:0]}, f);
  endtask
  task ea_case(input logic [15:0] a, input logic [1:0] f, input logic [1:0] i, input logic [15:0] e);
    @(posedge clk);
    op_addr <= a;
    op_form <= f;
    op_index <= i;
    repeat (2) @(posedge clk);
    #1 check(ea_addr, e);
  endtask
  task test_reset;
    int n;
    n = 0;
    while (fetch !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    check(pc, BOOT);
    check(mem_addr, BOOT);
    check(processor_flags[2], 1'b1);
    bus_rd(`OFS_PC_HIGH);
    check(rd_val, BOOT[15:8]);
    bus_rd(4'h8);
    check(rd_val, 8'h00);
    $display("reset test done");
  endtask
  task test_ea;
    do_op(`OP_LOAD, 2'h1, 8'h20);
    do_op(`OP_LOAD, 2'h2, 8'h01);
    ea_case(16'h12F0, `FORM_ABS, `IDX_X, 16'h1310);
    ea_case(16'h12F0, `FORM_ABS, `IDX_Y, 16'h12F1);
    ea_case(16'h00F0, `FORM_ZERO, `IDX_X, 16'h0010);
    ea_case(16'h0034, `FORM_SPECIAL, `IDX_NONE, 16'hFF34);
    $display("address test done");
  endtask
  task test_flags;
    do_op(`OP_LOAD, 2'h0, 8'hFF);
    do_op(`OP_BIT_TEST, 2'h0, 8'hC0);
    check(processor_flags[7:6], 2'h3);
    flag_op(`OP_CLR_V, 6, 1'b0);
    flag_op(`OP_SET_C, 0, 1'b1);
    flag_op(`OP_CLR_C, 0, 1'b0);
    flag_op(`OP_CLR_I, 2, 1'b0);
    flag_op(`OP_SET_I, 2, 1'b1);
    flag_op(`OP_SET_D, 3, 1'b1);
    flag_op(`OP_CLR_D, 3, 1'b0);
    flag_op(`OP_SET_T, 5, 1'b1);
    flag_op(`OP_CLR_T, 5, 1'b0);
    $display("flag test done");
  endtask
  task test_arith;
    bus_wr(`OFS_FLAGS, 8'h04);
    do_op(`OP_LOAD, 2'h0, 8'h7F);
    arith(`OP_ADD, 8'h01, 8'h80, 4'hC);
    arith(`OP_ADD, 8'h80, 8'h00, 4'h7);
    arith(`OP_LOAD, 8'h10, 8'h10, 4'h5);
    arith(`OP_SUB, 8'h20, 8'hF0, 4'h8);
    do_op(`OP_LOAD, 2'h0, 8'h81);
    arith(`OP_SHL, 8'h00, 8'h02, 4'h1);
    arith(`OP_ROR, 8'h00, 8'h81, 4'h8);
    arith(`OP_ROL, 8'h00, 8'h02, 4'h1);
    arith(`OP_SHR, 8'h00, 8'h01, 4'h0);
    bus_wr(`OFS_FLAGS, 8'h0C);
    do_op(`OP_LOAD, 2'h0, 8'h19);
    do_op(`OP_ADD, 2'h0, 8'h28);
    check(accumulator, 8'h47);
    bus_wr(`OFS_FLAGS, 8'h0D);
    do_op(`OP_LOAD, 2'h0, 8'h42);
    do_op(`OP_SUB, 2'h0, 8'h15);
    check(accumulator, 8'h27);
    $display("arithmetic test done");
  endtask
  task test_xmode;
    bus_wr(`OFS_FLAGS, 8'h24);
    op_mem1 <= 8'h05;
    snap = accumulator;
    do_op(`OP_ADD, 2'h0, 8'h03);
    repeat (3) @(posedge clk);
    check(mem_u.mem[16'h0020], 8'h08);
    check(accumulator, snap[7:0]);
    bus_wr(`OFS_FLAGS, 8'h04);
    $display("index mode test done");
  endtask
  task test_stack;
    bus_wr(`OFS_STACK_PTR, 8'h80);
    bus_wr(`OFS_CPU_MODE, 8'h04);
    do_op(`OP_LOAD, 2'h0, 8'h5A);
    do_op(`OP_PUSH_A, 2'h0, 8'h00);
    repeat (2) @(posedge clk);
    check(mem_u.mem[16'h0180], 8'h5A);
    bus_rd(`OFS_STACK_PTR);
    check(rd_val, 8'h7F);
    do_op(`OP_LOAD, 2'h0, 8'h00);
    do_op(`OP_PULL_A, 2'h0, 8'h00);
    repeat (4) @(posedge clk);
    check(accumulator, 8'h5A);
    bus_wr(`OFS_CPU_MODE, 8'h00);
    bus_wr(`OFS_FLAGS, 8'hC7);
    do_op(`OP_PUSH_P, 2'h0, 8'h00);
    repeat (2) @(posedge clk);
    check(mem_u.mem[16'h0080] & 8'hEF, 8'hC7);
    bus_wr(`OFS_FLAGS, 8'h00);
    do_op(`OP_PULL_P, 2'h0, 8'h00);
    repeat (4) @(posedge clk);
    check(processor_flags & 8'hEF, 8'hC7);
    $display("stack test done");
  endtask
  task test_irq;
    int n;
    bus_wr(`OFS_PC_LOW, 8'h56);
    bus_wr(`OFS_PC_HIGH, 8'h34);
    bus_wr(`OFS_STACK_PTR, 8'h70);
    do_op(`OP_CALL, 2'h0, 8'h00);
    repeat (4) @(posedge clk);
    check({mem_u.mem[16'h0070], mem_u.mem[16'h006F]}, 16'h3456);
    irq_req <= 1'b1;
    n = 0;
    repeat (8) @(posedge clk) n += irq_ack;
    check(n[15:0], 16'h0000);
    snap = pc;
    bus_wr(`OFS_FLAGS, 8'h00);
    n = 0;
    while (irq_ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    irq_req <= 1'b0;
    repeat (6) @(posedge clk);
    check({mem_u.mem[16'h006E], mem_u.mem[16'h006D]}, snap);
    check(mem_u.mem[16'h006C][4], 1'b0);
    check(processor_flags[2], 1'b1);
    do_op(`OP_BREAK, 2'h0, 8'h00);
    repeat (5) @(posedge clk);
    check(mem_u.mem[16'h0069][4], 1'b1);
    bus_rd(`OFS_STACK_PTR);
    check(rd_val, 8'h68);
    @(posedge clk);
    op_addr <= 16'h12FF;
    do_op(`OP_PC_LOAD, 2'h0, 8'h00);
    do_op(`OP_PC_INC, 2'h0, 8'h00);
    check(pc, 16'h1300);
    check(mem_addr, 16'h1300);
    check(fetch, 1'b1);
    $display("interrupt test done");
  endtask
  initial
  begin
    srst = 1'b1;
    {reg_wr, reg_rd, op_valid, irq_req} = 4'h0;
    {reg_addr, reg_wdata, op_code, op_sel, op_data, op_mem1} = 35'h0;
    {op_addr, op_form, op_index} = 20'h0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    test_reset;
    test_ea;
    test_flags;
    test_arith;
    test_xmode;
    test_stack;
    test_irq;
    give_verdict;
  end
  initial
  begin
    repeat (4000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
endmodule
`default_nettype wire
